//--- verilog/ext_exec_defs.svh
`ifndef EXT_EXEC_DEFS_SVH
`define EXT_EXEC_DEFS_SVH

`define OPC_MOVE_IDX 8'hEB
`define OPC_SECOND 4'hF
`define OPC_PUSH 8'hFA
`define OPC_PSUB 8'hE9
`define PSEL_RETURN 2'h3
`define PSEL_FRAME 2'h2
`define IDX_LIMIT 8'h5F
`define ADDR_PCL 12'hFF9
`define ADDR_RETURN_TOP_LOW 12'hFFD
`define ADDR_RETURN_TOP_HIGH 12'hFFE
`define ADDR_RETURN_TOP_UPPER 12'hFFF
`define ACCESS_HI_BASE 12'hF00
`define INDF0_LO 12'hFEB
`define INDF0_HI 12'hFEF
`define INDF1_LO 12'hFE3
`define INDF1_HI 12'hFE7
`define INDF2_LO 12'hFDB
`define INDF2_HI 12'hFDF
`define FSR_RESET 12'h000
`define FSR_DEC 12'h001
`define ADDR_ZERO 12'h000
`define DATA_ZERO 8'h00
`define PC_RESET 21'h000000
`define PSEL_FSR0 2'h0
`define PSEL_FSR1 2'h1

`endif

//--- verilog/ext_exec_pkg.sv
package ext_exec_pkg;
  typedef enum logic [1:0] {
    ST_FETCH,
    ST_MOVE2,
    ST_IDLE
  } exec_state_t;
  typedef logic [11:0] daddr_t;
endpackage : ext_exec_pkg

//--- verilog/ext_exec.sv
`timescale 1ns/100ps
`include "ext_exec_defs.svh"

// Behaviour
// - indexed-to-file: source frame plus offset, literal destination
// - decode EB first word, F second word
// - both moves reach whole 12-bit space
// - indirect register as source reads 00h
// - indexed-to-indexed: both addresses frame plus offset
// - indirect register as indexed destination suppresses the write
// - push literal at frame, then decrement frame
// - push decoded FA, one cycle
// - subtract 6-bit literal from selected pointer
// - pointer subtract decoded E9 single word
// - select 11 subtracts frame then returns
// - return loads counter from stack, idle cycle
// - extension switches standard operands to indexed
// - extension off: access bank or bank select
// - on, access 0, f<=5Fh: frame plus f
// - above 5Fh or access 1 stays literal
// - destination select bit keeps normal meaning
// - frame zero maps to original access bank
module ext_exec (
  input wire logic clk,
  input wire logic rstn,
  input wire logic extension_enable_config,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic ext_decoded,
  input wire logic [7:0] bank_select_register,
  input wire logic [7:0] std_file_addr,
  input wire logic std_access_bit,
  input wire logic std_dest_bit,
  output ext_exec_pkg::daddr_t std_eff_addr,
  output logic std_result_to_w,
  output ext_exec_pkg::daddr_t rd_addr,
  input wire logic [7:0] rd_data,
  output ext_exec_pkg::daddr_t wr_addr,
  output logic [7:0] wr_data,
  output logic wr_en,
  input wire logic [20:0] return_stack_top,
  output logic [20:0] pc_load_value,
  output logic pc_load,
  output logic return_pop,
  output ext_exec_pkg::daddr_t fsr0_q,
  output ext_exec_pkg::daddr_t fsr1_q,
  output ext_exec_pkg::daddr_t frame_pointer_q
);
  import ext_exec_pkg::*;

  exec_state_t state_q;
  daddr_t dst_addr;
  logic [7:0] data_q;
  logic idx_dst_q;

  // extended opcodes are plain standard codes when the bit is clear
  logic en;
  assign en = extension_enable_config;

  logic take;
  logic dec_move;
  logic dec_push;
  logic dec_psub;
  logic dec_ret;
  logic second_ok;
  logic idx_mode;
  logic [1:0] psel;
  logic [5:0] lit6;
  logic [2:0] src_hit;
  logic [2:0] dst_hit;
  logic src_ind;
  logic dst_ind;

  assign take = instr_valid && state_q == ST_FETCH;
  assign dec_move = en && instr[15:8] == `OPC_MOVE_IDX;
  assign dec_push = en && instr[15:8] == `OPC_PUSH;
  assign dec_psub = en && instr[15:8] == `OPC_PSUB;
  assign psel = instr[7:6];
  assign lit6 = instr[5:0];
  assign dec_ret = dec_psub && psel == `PSEL_RETURN;
  assign ext_decoded = take && (dec_move || dec_push || dec_psub);

  // the idle cycle of the return takes no word
  assign instr_ready = state_q != ST_IDLE;

  // a second word without the prefix writes nothing and ends the move
  assign second_ok = state_q == ST_MOVE2 && instr_valid
      && instr[15:12] == `OPC_SECOND;

  function automatic daddr_t idx(input daddr_t base, input logic [6:0] z);
    return base + daddr_t'(z);
  endfunction : idx

  // source read address: first word of either move
  always_comb begin
    rd_addr = idx(frame_pointer_q, instr[6:0]);
  end

  // destination: offset from frame, or the 12-bit literal
  always_comb begin
    dst_addr = `ADDR_ZERO;
    if (idx_dst_q) begin
      dst_addr = idx(frame_pointer_q, instr[6:0]);
    end else begin
      dst_addr = instr[11:0];
    end
  end

  // the three indirect windows, once for each address
  indirect_window #(
    .LO(`INDF0_LO),
    .HI(`INDF0_HI)
  ) i_src_win0 (
    .addr(rd_addr),
    .hit(src_hit[0])
  );

  indirect_window #(
    .LO(`INDF1_LO),
    .HI(`INDF1_HI)
  ) i_src_win1 (
    .addr(rd_addr),
    .hit(src_hit[1])
  );

  indirect_window #(
    .LO(`INDF2_LO),
    .HI(`INDF2_HI)
  ) i_src_win2 (
    .addr(rd_addr),
    .hit(src_hit[2])
  );

  indirect_window #(
    .LO(`INDF0_LO),
    .HI(`INDF0_HI)
  ) i_dst_win0 (
    .addr(dst_addr),
    .hit(dst_hit[0])
  );

  indirect_window #(
    .LO(`INDF1_LO),
    .HI(`INDF1_HI)
  ) i_dst_win1 (
    .addr(dst_addr),
    .hit(dst_hit[1])
  );

  indirect_window #(
    .LO(`INDF2_LO),
    .HI(`INDF2_HI)
  ) i_dst_win2 (
    .addr(dst_addr),
    .hit(dst_hit[2])
  );

  assign src_ind = |src_hit;
  assign dst_ind = |dst_hit;

  // standard operand addressing
  assign idx_mode = en && !std_access_bit
      && std_file_addr <= `IDX_LIMIT;

  // frame zero leaves the low access bank where it was
  always_comb begin
    if (idx_mode) begin
      std_eff_addr = frame_pointer_q + daddr_t'(std_file_addr);
    end else if (std_access_bit) begin
      // only four bank bits exist in a 4096-byte space
      std_eff_addr = {bank_select_register[3:0], std_file_addr};
    end else if (std_file_addr <= `IDX_LIMIT) begin
      std_eff_addr = daddr_t'(std_file_addr);
    end else begin
      // upper access half maps to the special registers
      std_eff_addr = `ACCESS_HI_BASE | daddr_t'(std_file_addr);
    end
  end

  // the result goes where the select bit says
  assign std_result_to_w = !std_dest_bit;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_FETCH;
    end else begin
      case (state_q)
        ST_FETCH: begin
          if (take && dec_move) begin
            state_q <= ST_MOVE2;
          end else if (take && dec_ret) begin
            state_q <= ST_IDLE;
          end
        end
        ST_MOVE2: begin
          if (instr_valid) begin
            state_q <= ST_FETCH;
          end
        end
        ST_IDLE: state_q <= ST_FETCH;
        default: state_q <= ST_FETCH;
      endcase
    end
  end

  // first move word: latch source data, with indirect reads as zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= `DATA_ZERO;
      idx_dst_q <= 1'b0;
    end else if (take && dec_move) begin
      data_q <= src_ind ? `DATA_ZERO : rd_data;
      idx_dst_q <= instr[7];
    end
  end

  // second move word or push: destination and write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_en <= 1'b0;
      wr_addr <= `ADDR_ZERO;
      wr_data <= `DATA_ZERO;
    end else begin
      wr_en <= 1'b0;
      if (second_ok) begin
        // forbidden destinations are the program's duty
        wr_en <= !(idx_dst_q && dst_ind);
        wr_addr <= dst_addr;
        wr_data <= data_q;
      end else if (take && dec_push) begin
        wr_en <= 1'b1;
        wr_addr <= frame_pointer_q;
        wr_data <= instr[7:0];
      end
    end
  end

  // pointer subtract leaves the status flags alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fsr0_q <= `FSR_RESET;
    end else if (take && dec_psub && psel == `PSEL_FSR0) begin
      fsr0_q <= fsr0_q - daddr_t'(lit6);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fsr1_q <= `FSR_RESET;
    end else if (take && dec_psub && psel == `PSEL_FSR1) begin
      fsr1_q <= fsr1_q - daddr_t'(lit6);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_pointer_q <= `FSR_RESET;
    end else if (take && dec_push) begin
      // the write above already took the old value as its address
      frame_pointer_q <= frame_pointer_q - `FSR_DEC;
    end else if (take && dec_psub && psel[1]) begin
      // select 2 and the return form both act on the frame pointer
      frame_pointer_q <= frame_pointer_q - daddr_t'(lit6);
    end
  end

  // return: counter load and stack pop, then one idle cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_load <= 1'b0;
      return_pop <= 1'b0;
      pc_load_value <= `PC_RESET;
    end else begin
      pc_load <= 1'b0;
      return_pop <= 1'b0;
      if (take && dec_ret) begin
        pc_load <= 1'b1;
        return_pop <= 1'b1;
        pc_load_value <= return_stack_top;
      end
    end
  end
endmodule : ext_exec

// one window of indirect-access registers; a hit forces the
// moved data to zero or cancels an indexed-destination write
module indirect_window #(
  parameter logic [11:0] LO = `INDF0_LO,
  parameter logic [11:0] HI = `INDF0_HI
) (
  input wire ext_exec_pkg::daddr_t addr,
  output logic hit
);
  import ext_exec_pkg::*;

  assign hit = addr >= LO && addr <= HI;
endmodule : indirect_window

//--- tb/ext_exec_monitor.sv
`timescale 1ns/100ps
module ext_exec_monitor (
  input wire logic clk, rstn, extension_enable_config, ext_decoded,
  input wire logic instr_ready, std_access_bit, std_dest_bit,
  input wire logic std_result_to_w, wr_en, pc_load, return_pop,
  input wire logic [15:0] instr,
  input wire logic [7:0] bank_select_register, std_file_addr, wr_data,
  input wire logic [20:0] return_stack_top, pc_load_value,
  input wire ext_exec_pkg::daddr_t std_eff_addr, wr_addr, frame_pointer_q
);
  import ext_exec_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire push = ext_decoded && instr[15:8] == 8'hFA;
  wire ret = ext_decoded && instr[15:6] == 10'h3A7;
  wire low = std_file_addr <= 8'h5F;
  a_push_write: assert property (push |=> wr_en
    && wr_addr == $past(frame_pointer_q) && wr_data == $past(instr[7:0]))
    else $error("push write");
  a_push_step: assert property (push |=>
    frame_pointer_q == $past(frame_pointer_q) - 12'h001) else $error("push");
  a_ret_load: assert property (ret |=> pc_load && return_pop
    && pc_load_value == $past(return_stack_top)) else $error("ret load");
  a_ret_idle: assert property (ret |=> !instr_ready ##1
    instr_ready && !pc_load) else $error("ret idle");
  a_off_quiet: assert property (!extension_enable_config |->
    !ext_decoded) else $error("decode off");
  a_std_index: assert property (extension_enable_config
    && !std_access_bit && low |->
    std_eff_addr == frame_pointer_q + std_file_addr) else $error("index");
  a_std_literal: assert property (!std_access_bit
    && !(extension_enable_config && low) |->
    std_eff_addr == {low ? 4'h0 : 4'hF, std_file_addr}) else $error("acc");
  a_std_bank: assert property (std_access_bit |->
    std_eff_addr == {bank_select_register[3:0], std_file_addr})
    else $error("bank");
  a_dest_sel: assert property (
    std_result_to_w == !std_dest_bit) else $error("dest");
  c_push: cover property (push);
  c_ret: cover property (ret);
  c_move: cover property (ext_decoded && instr[15:8] == 8'hEB);
endmodule : ext_exec_monitor
bind ext_exec ext_exec_monitor i_mon (.*);

//--- tb/data_mem_model.sv
`timescale 1ns/100ps
module data_mem_model (
  input wire logic clk, wr_en,
  input wire logic [11:0] rd_addr, wr_addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  logic [7:0] mem [4096];
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 5 + 1);
  // every cell is backed so both moves can reach any address
  assign rd_data = mem[rd_addr];
  always @(posedge clk) if (wr_en) mem[wr_addr] <= wr_data;
endmodule : data_mem_model

//--- tb/tb_ext_exec.sv
`timescale 1ns/100ps
module tb_ext_exec;
  import ext_exec_pkg::*;
  logic clk, rstn, extension_enable_config, instr_valid, instr_ready;
  logic ext_decoded, std_access_bit, std_dest_bit, std_result_to_w;
  logic wr_en, pc_load, return_pop;
  logic [15:0] instr, w;
  logic [7:0] bank_select_register, std_file_addr, rd_data, wr_data;
  logic [20:0] return_stack_top, pc_load_value;
  daddr_t std_eff_addr, rd_addr, wr_addr, fsr0_q, fsr1_q, frame_pointer_q;
  logic [31:0] r, seed = 32'hC812D405;
  int n_mismatch, num_checks, cyc, m[3];
  ext_exec i_dut (.*);
  data_mem_model i_mem (.*);
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic ind(daddr_t a);
    return a inside {[12'hFDB:12'hFDF], [12'hFE3:12'hFE7], [12'hFEB:12'hFEF]};
  endfunction : ind
  task automatic check(input logic [39:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge clk) if (++cyc == 2000) begin
    n_mismatch++;
    finish_test();
  end
  task automatic op(input logic [15:0] w1, w2, input logic e);
    daddr_t s, d;
    logic [7:0] v;
    logic mv, we, rt;
    mv = e && w1[15:8] == 8'hEB;
    rt = e && w1[15:6] == 10'h3A7;
    s = 12'(m[2] + w1[6:0]);
    d = w1[7] ? 12'(m[2] + w2[6:0]) : w2[11:0];
    v = ind(s) ? 8'h00 : i_mem.mem[s];
    we = mv && !(w1[7] && ind(d));
    if (e && w1[15:8] == 8'hFA) begin
      we = 1;
      d = 12'(m[2]);
      v = w1[7:0];
      m[2]--;
    end
    if (e && w1[15:8] == 8'hE9) m[rt ? 2 : w1[7:6]] -= w1[5:0];
    extension_enable_config = e;
    instr = w1;
    instr_valid = 1;
    {std_access_bit, std_dest_bit, bank_select_register, std_file_addr} =
      18'(rnd());
    return_stack_top = 21'(rnd());
    @(posedge clk) #1;
    if (mv) begin
      instr = w2;
      @(posedge clk) #1;
    end
    check(wr_en, we);
    if (we) check({wr_addr, wr_data},
      {d, v});
    check({pc_load, instr_ready}, {rt, !rt});
    if (rt) check(pc_load_value, return_stack_top);
    check({fsr0_q, fsr1_q, frame_pointer_q}, {12'(m[0]), 12'(m[1]),
      12'(m[2])});
    if (rt) @(posedge clk) #1;
  endtask : op
  initial begin
    {rstn, instr_valid, extension_enable_config, std_access_bit} = 0;
    {std_dest_bit, bank_select_register, std_file_addr, instr} = 0;
    return_stack_top = 0;
    repeat (3) @(posedge clk);
    #1 rstn = 1;
    op(16'hE9D1, 0, 1);
    op(16'hEB00, 16'hF123, 1);
    op(16'hEB80, 16'hF000, 1);
    op(16'hFA5A, 0, 0);
    repeat (80) begin
      r = rnd();
      w = r[0] ? {8'hEB, r[15:8]} : {r[1] ? 8'hFA : 8'hE9, r[15:8]};
      // literal destinations stay clear of counter and return-top bytes
      op(w, {4'hF, r[27:16] > 12'hFF8 ? 12'hFF8 : r[27:16]}, r[31:29] != 0);
    end
    finish_test();
  end
endmodule : tb_ext_exec
